// ### ssl_regs.svh
// timing constants and defaults for the serial stream loader
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// configuration clock period in ns (20 MHz)
`define SSL_CLK_NS 50
// default memory address width (4 Mbit memory)
`define SSL_ADDR_W 19
// bits per memory word
`define SSL_BYTE_W 8
// clocks to wait after the ready line rises for older targets
`define SSL_LEGACY_WAIT 40
// least low time of the clear request in ns
`define SSL_CLR_NS 300
// clear request length in cycles, rounded up
`define SSL_CLR_CYC ((`SSL_CLR_NS + `SSL_CLK_NS - 1) / `SSL_CLK_NS)
// cycles from a new address to a settled, synchronised data byte
`define SSL_FETCH_LAT 6
// bit position of the first bit of a byte on the wire
`define SSL_FIRST_BIT 0

`endif

// ### ssl_pkg.sv
// types shared by the serial stream loader
`default_nettype none
package ssl_pkg;
    typedef enum logic [2:0] {
        SSL_IDLE,
        SSL_DELAY,
        SSL_RUN,
        SSL_RETRY,
        SSL_DONE
    } ssl_state_t;
endpackage
`default_nettype wire

// ### ssl_loader.sv
// parallel memory to serial configuration stream loader with its byte fifo
//
// Overview of operation
// RULE1: address width parameter, default nineteen lines
// RULE2: width 17..20 matches stored bit count
// RULE3: error low during load returns to reset
// RULE4: optional clear pulse then full retry
// RULE5: extra top bits decode to memory selects
// RULE6: two memories: top bit picks select
// RULE7: bits leave in stored order, lsb first
// RULE8: legacy mode waits forty clocks before shifting
// RULE9: alternatively stream carries forty dummy bits
// RULE10: target counts clocks against length count
// RULE11: newer targets start shifting at once
// RULE12: chained targets pass surplus data onward
// RULE13: target pulls ready low on error
// RULE14: whole byte shifted before next fetch
// RULE15: completion releases memory and data pin
// RULE16: clocked by the shared configuration clock
// RULE17: new pass restarts address and bit
`include "ssl_regs.svh"
`default_nettype none

// ************************************************************
// byte fifo
// ************************************************************
module ssl_fifo #(
    parameter int WIDTH = `SSL_BYTE_W,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW:0] wr_ff, rd_ff;
    logic push, pop;

    // the pointer wrap bit needs a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth not a power of two");

    // full when pointers differ only in the wrap bit
    assign in_ready_o = !((wr_ff[PW] != rd_ff[PW]) && (wr_ff[PW-1:0] == rd_ff[PW-1:0]));
    assign out_valid_o = (wr_ff != rd_ff);
    assign out_data_o = mem_ff[rd_ff[PW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage needs no reset; valid flags come from pointers
    always_ff @(posedge clk_i) begin
        if (push)
            mem_ff[wr_ff[PW-1:0]] <= in_data_i;
    end

    // pointers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else if (flush_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (push)
                wr_ff <= wr_ff + 1'b1;
            if (pop)
                rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule

// ************************************************************
// loader top
// ************************************************************
module ssl_loader #(
    parameter int ADDR_W = `SSL_ADDR_W,
    parameter int NUM_MEM = 1,
    parameter bit LEGACY_WAIT_EN = 1'b0, // RULE8
    parameter int WAIT_CYC = `SSL_LEGACY_WAIT,
    parameter bit AUTO_RETRY_EN = 1'b0,
    parameter int FIFO_DEPTH = 16
) (
    // shared configuration clock and reset
    input wire logic ref_clk_i, // RULE16
    input wire logic arst_n_i,
    // memory side
    input wire logic [`SSL_BYTE_W-1:0] prom_data_i,
    output logic [ADDR_W+$clog2(NUM_MEM)-1:0] addr_o,
    output logic [NUM_MEM-1:0] mem_select_n_o,
    // target side
    input wire logic ready_err_i,
    input wire logic done_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic clear_req_n_o
);
    localparam int SW = $clog2(NUM_MEM);
    localparam int TW = ADDR_W + SW;
    localparam int BW = `SSL_BYTE_W;
    localparam int CLR_CYC = `SSL_CLR_CYC;
    localparam int LAT = `SSL_FETCH_LAT;

    ssl_pkg::ssl_state_t st_ff;
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [2:0] rdy_s_ff;
    logic [2:0] done_s_ff;
    logic [BW-1:0] dat_s1_ff, dat_s2_ff, dat_s3_ff, dat_f_ff;
    logic rdy_f_ff, done_f_ff, rdy_prev_ff;
    logic [TW-1:0] addr_ff;
    logic [7:0] wait_cnt_ff;
    logic [3:0] lat_ff;
    logic [BW-1:0] sh_ff;
    logic [3:0] bits_ff;
    logic start, abort, push, pop, fetch_ok, f_ready, f_valid;
    logic [BW-1:0] f_data;

    // refuse sizes that the counters and the select decoder cannot serve
    if (ADDR_W < 17 || ADDR_W > 20) $error("address width out of range"); // RULE1 RULE2
    if (NUM_MEM < 1 || (NUM_MEM & (NUM_MEM - 1)) != 0) $error("bad memory count"); // RULE5
    if (WAIT_CYC < 1 || WAIT_CYC > 255) $error("wait count out of range");

    // binary decode of the top address bits into active-low selects
    function automatic logic [NUM_MEM-1:0] sel_decode(input logic [TW-1:0] a);
        logic [NUM_MEM-1:0] s;
        s = '1;
        for (int i = 0; i < NUM_MEM; i++)
            if (NUM_MEM == 1 || int'(a >> ADDR_W) == i)
                s[i] = 1'b0;
        return s;
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_s_ff <= 3'h0;
            done_s_ff <= 3'h0;
            dat_s1_ff <= 8'h00;
            dat_s2_ff <= 8'h00;
            dat_s3_ff <= 8'h00;
            dat_f_ff <= 8'h00;
            rdy_f_ff <= 1'b0;
            done_f_ff <= 1'b0;
        end else begin
            rdy_s_ff <= {rdy_s_ff[1:0], ready_err_i};
            done_s_ff <= {done_s_ff[1:0], done_i};
            dat_s1_ff <= prom_data_i;
            dat_s2_ff <= dat_s1_ff;
            dat_s3_ff <= dat_s2_ff;
            if (rdy_s_ff[1] == rdy_s_ff[2])
                rdy_f_ff <= rdy_s_ff[2];
            if (done_s_ff[1] == done_s_ff[2])
                done_f_ff <= done_s_ff[2];
            if (dat_s2_ff == dat_s3_ff)
                dat_f_ff <= dat_s3_ff;
        end
    end

    // a pass starts on a rising ready line; a falling one mid-load aborts
    assign start = (st_ff == ssl_pkg::SSL_IDLE) && rdy_f_ff && !rdy_prev_ff;
    assign abort = !rdy_f_ff && !done_f_ff &&
                   (st_ff == ssl_pkg::SSL_RUN || st_ff == ssl_pkg::SSL_DELAY);

    // control state machine; the wait counter also times the clear pulse
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ssl_pkg::SSL_IDLE;
            wait_cnt_ff <= 8'h00;
            rdy_prev_ff <= 1'b0;
        end else begin
            rdy_prev_ff <= rdy_f_ff;
            wait_cnt_ff <= wait_cnt_ff + 8'h01;
            if (done_f_ff && st_ff != ssl_pkg::SSL_DONE) begin
                st_ff <= ssl_pkg::SSL_DONE; // RULE15
            end else if (abort) begin
                wait_cnt_ff <= 8'h00;
                st_ff <= AUTO_RETRY_EN ? ssl_pkg::SSL_RETRY : ssl_pkg::SSL_IDLE; // RULE3 RULE4
            end else begin
                unique case (st_ff)
                    ssl_pkg::SSL_IDLE: begin
                        wait_cnt_ff <= 8'h00;
                        if (start && LEGACY_WAIT_EN)
                            st_ff <= ssl_pkg::SSL_DELAY; // RULE8
                        else if (start)
                            st_ff <= ssl_pkg::SSL_RUN; // RULE11
                    end
                    ssl_pkg::SSL_DELAY: begin
                        if (wait_cnt_ff == 8'(WAIT_CYC - 1))
                            st_ff <= ssl_pkg::SSL_RUN; // RULE8
                    end
                    ssl_pkg::SSL_RUN: wait_cnt_ff <= 8'h00;
                    ssl_pkg::SSL_RETRY: begin
                        if (wait_cnt_ff == 8'(CLR_CYC - 1))
                            st_ff <= ssl_pkg::SSL_IDLE; // RULE4
                    end
                    ssl_pkg::SSL_DONE: begin
                        if (!rdy_f_ff && !done_f_ff)
                            st_ff <= ssl_pkg::SSL_IDLE;
                    end
                endcase
            end
        end
    end

    // clear request held low for the whole retry state
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n)
            clear_req_n_o <= 1'b1;
        else
            clear_req_n_o <= !(abort && AUTO_RETRY_EN) &&
                             !(st_ff == ssl_pkg::SSL_RETRY &&
                               wait_cnt_ff != 8'(CLR_CYC - 1)); // RULE4
    end

    // fetch: hold each address until its byte has settled through the synchroniser
    assign fetch_ok = (st_ff == ssl_pkg::SSL_RUN) && !done_f_ff && rdy_f_ff; // RULE3
    assign push = fetch_ok && (lat_ff == 4'(LAT)) && f_ready;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= '0;
            lat_ff <= 4'h0;
        end else if (start) begin
            addr_ff <= '0; // RULE17
            lat_ff <= 4'h0;
        end else if (push) begin
            addr_ff <= addr_ff + 1'b1; // RULE14
            lat_ff <= 4'h0;
        end else if (fetch_ok && lat_ff != 4'(LAT)) begin
            lat_ff <= lat_ff + 4'h1;
        end
    end

    // address and selects; selects drop out once the target is done
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_o <= '0;
            mem_select_n_o <= '1;
        end else begin
            addr_o <= addr_ff;
            if (st_ff == ssl_pkg::SSL_RUN && !done_f_ff)
                mem_select_n_o <= sel_decode(addr_ff); // RULE5 RULE6
            else
                mem_select_n_o <= '1; // RULE15
        end
    end

    ssl_fifo #(
        .WIDTH(BW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .flush_i(start),
        .in_valid_i(fetch_ok && lat_ff == 4'(LAT)),
        .in_ready_o(f_ready),
        .in_data_i(dat_f_ff),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_data)
    );

    // shifter: lsb first, one bit per clock; the fifo must stay ahead
    // because the target takes a bit on every clock and cannot be stalled
    assign pop = fetch_ok && (bits_ff == 4'h0);
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff <= 8'h00;
            bits_ff <= 4'h0;
            serial_data_o <= 1'b1;
            serial_data_oe_o <= 1'b0;
        end else if (start || !fetch_ok) begin
            bits_ff <= 4'h0; // RULE17
            serial_data_o <= 1'b1;
            serial_data_oe_o <= 1'b0; // RULE15
        end else if (bits_ff != 4'h0) begin
            serial_data_o <= sh_ff[`SSL_FIRST_BIT]; // RULE7
            sh_ff <= sh_ff >> 1;
            bits_ff <= bits_ff - 4'h1;
        end else if (f_valid) begin
            serial_data_o <= f_data[`SSL_FIRST_BIT]; // RULE7 RULE14
            sh_ff <= f_data >> 1;
            bits_ff <= 4'(BW - 1);
            serial_data_oe_o <= 1'b1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    err_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE3
        (abort && !AUTO_RETRY_EN) |=> st_ff == ssl_pkg::SSL_IDLE && !serial_data_oe_o)
        else $error("error line low did not abort the load");
    retry_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE4
        (abort && AUTO_RETRY_EN) |=> !clear_req_n_o[*6])
        else $error("clear request pulse too short");
    sel_decode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE6
        ($past(st_ff) == ssl_pkg::SSL_RUN && !$past(done_f_ff))
        |-> mem_select_n_o == sel_decode($past(addr_ff)))
        else $error("memory select does not follow top address bits");
    legacy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE8
        (st_ff == ssl_pkg::SSL_DELAY && wait_cnt_ff == 8'(WAIT_CYC - 1) && rdy_f_ff)
        |=> st_ff == ssl_pkg::SSL_RUN && !serial_data_oe_o)
        else $error("legacy wait did not end at its count");
    no_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE11
        (start && !LEGACY_WAIT_EN && !done_f_ff) |=> st_ff == ssl_pkg::SSL_RUN)
        else $error("newer target start was delayed");
    bit_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE7
        (fetch_ok && !start && bits_ff != 4'h0) |=> serial_data_o == $past(sh_ff[0]))
        else $error("serial bit out of stored order");
    byte_whole_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE14
        (pop && f_valid && !start) |=> bits_ff == 4'(BW - 1) ##1 !pop[*6])
        else $error("byte not fully shifted before next one");
    done_iso_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE15
        done_f_ff |=> ##1 (mem_select_n_o == '1 && !serial_data_oe_o))
        else $error("memory or data pin not released on completion");
    restart_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // RULE17
        start |=> addr_ff == '0 && bits_ff == 4'h0)
        else $error("new pass did not restart address and bit");
endmodule
`default_nettype wire

// ### ssl_prom_model.sv
// behavioural byte-wide memory model that stands on the loader's memory side
`default_nettype none

module ssl_prom_model #(
    parameter int AW = 20
) (
    // memory pins
    input wire logic [AW-1:0] addr_i,
    input wire logic sel_n_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // stored image
    // ************************************************************
    // fill byte, then fill nibble plus preamble, then a varying pattern
    function automatic logic [7:0] byte_at(input logic [AW-1:0] a);
        if (a == '0) begin
            return 8'hFF;
        end
        if (a == 1) begin
            return 8'h4F;
        end
        return a[7:0] * 8'h1D + 8'h03;
    endfunction

    // ************************************************************
    // access timing
    // ************************************************************
    // until access time runs out the pins show the inverse of the old byte,
    // so a loader sampling too early sees wrong data instead of luck
    initial data_o = 8'h00;
    always @(addr_i or sel_n_i) begin
        data_o = ~data_o;
        if (!sel_n_i) begin
            data_o <= #90 byte_at(addr_i);
        end
    end
endmodule

// ************************************************************
// configuration target
// ************************************************************
// counts clocks while its ready line is high and declares itself done when the
// count reaches the stream's length count; later bits are handed down the chain
module ssl_target_model #(
    parameter int LEN = 160
) (
    // configuration clock and lines
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic din_i,
    output logic dout_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;

    // the count restarts whenever the ready line is low
    always @(posedge clk_i) begin
        if (!ready_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            dout_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
            if (cnt == LEN - 1)
                done_o <= 1'b1;
            if (cnt >= LEN)
                dout_o <= din_i;
        end
    end
endmodule

`default_nettype wire

// ### ssl_loader_tb_top.sv
// self-checking bench for the serial stream loader
`default_nettype none
`include "ssl_regs.svh"
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, m); end end

module ssl_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ready_err_i = 1'b0;
    logic done_i;
    logic done_t1, done_t2, chain_d;
    logic [19:0] addr_a;
    logic [1:0] sel_a;
    logic [7:0] data_a;
    logic sd_a, oe_a, clr_a;
    logic [18:0] addr_b;
    logic [0:0] sel_b;
    logic [7:0] data_b;
    logic sd_b, oe_b, clr_b;
    logic q_a[$];
    int err_total = 0;
    int n_tests = 0;

    // ************************************************************
    // loaders and memories
    // ************************************************************
    // two memory selects on the first loader with a memory on the low one only, legacy wait and retry on the second
    ssl_loader #(.NUM_MEM(2)) ssl_loader_inst (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .prom_data_i(data_a),
        .addr_o(addr_a), .mem_select_n_o(sel_a), .ready_err_i(ready_err_i),
        .done_i(done_i), .serial_data_o(sd_a), .serial_data_oe_o(oe_a),
        .clear_req_n_o(clr_a));
    ssl_loader #(.LEGACY_WAIT_EN(1'b1), .AUTO_RETRY_EN(1'b1)) ssl_loader_inst_b (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .prom_data_i(data_b),
        .addr_o(addr_b), .mem_select_n_o(sel_b), .ready_err_i(ready_err_i),
        .done_i(done_i), .serial_data_o(sd_b), .serial_data_oe_o(oe_b),
        .clear_req_n_o(clr_b));
    ssl_prom_model #(.AW(20)) ssl_prom_model_inst (
        .addr_i(addr_a), .sel_n_i(sel_a[0]), .data_o(data_a));
    ssl_prom_model #(.AW(19)) ssl_prom_model_inst_b (
        .addr_i(addr_b), .sel_n_i(sel_b[0]), .data_o(data_b));
    // two chained targets share ready and done; the first passes surplus bits on
    ssl_target_model #(.LEN(96)) ssl_target_model_inst (
        .clk_i(ref_clk_i), .ready_i(ready_err_i), .din_i(sd_a), .dout_o(chain_d),
        .done_o(done_t1));
    ssl_target_model #(.LEN(160)) ssl_target_model_inst_b (
        .clk_i(ref_clk_i), .ready_i(ready_err_i), .din_i(chain_d), .dout_o(),
        .done_o(done_t2));
    // completion lines are wired together: high only once every target is done
    assign done_i = done_t1 && done_t2;

    // shared configuration clock, one for loader and target alike
    initial forever #25 ref_clk_i = ~ref_clk_i;
    // record every driven serial bit of the first loader
    always @(negedge ref_clk_i) if (oe_a === 1'b1) q_a.push_back(sd_a);

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bounded wait on oe of either loader, the retry clear line or completion
    task automatic wait_sig(input int which, input logic v, output int cyc);
        cyc = 0;
        while (((which == 0) ? oe_a : (which == 1) ? oe_b :
                (which == 2) ? clr_b : done_i) !== v) begin
            @(negedge ref_clk_i);
            cyc++;
            if (cyc > 400) begin
                err_total++;
                $display("MISMATCH %0t wait limit", $time);
                close_out();
            end
        end
    endtask

    // compare the recorded bits, lsb first, with stored bytes from address 0
    task automatic check_bytes(input int n);
        logic [7:0] got;
        int w;
        for (int k = 0; k < n; k++) begin
            w = 0;
            while (q_a.size() < 8 * (k + 1)) begin
                @(negedge ref_clk_i);
                w++;
                if (w > 400) begin
                    err_total++;
                    $display("MISMATCH %0t byte wait limit", $time);
                    close_out();
                end
            end
            for (int i = 0; i < 8; i++) got[i] = q_a[8 * k + i];
            `CHK(got, ssl_prom_model_inst.byte_at(20'(k)), "serial byte")
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_start();
        int ta, tb;
        ready_err_i = 1'b1;
        wait_sig(0, 1'b1, ta);
        `CHK(ta <= 16, 1'b1, "newer target start delayed")
        `CHK(sel_a, 2'b10, "select decode for low half")
        `CHK(addr_a[19], 1'b0, "top address bit")
        wait_sig(1, 1'b1, tb);
        `CHK(tb >= `SSL_LEGACY_WAIT && tb <= `SSL_LEGACY_WAIT + 1, 1'b1, "legacy wait")
        check_bytes(3);
        `CHK(clr_a, 1'b1, "clear request without retry")
        $display("test start done");
    endtask

    task automatic t_abort();
        int c, lo;
        // target reports an error mid-load
        ready_err_i = 1'b0;
        wait_sig(2, 1'b0, c);
        lo = 0;
        while (clr_b === 1'b0 && lo < 20) begin
            @(negedge ref_clk_i);
            lo++;
        end
        `CHK(lo, `SSL_CLR_CYC, "clear pulse length")
        `CHK(oe_a, 1'b0, "data still driven after error")
        `CHK(sel_a, 2'b11, "memory still selected after error")
        `CHK(clr_a, 1'b1, "clear request without retry")
        repeat (20) @(negedge ref_clk_i);
        `CHK(oe_a, 1'b0, "restart without ready rise")
        q_a.delete();
        ready_err_i = 1'b1;
        wait_sig(0, 1'b1, c);
        check_bytes(2);
        $display("test abort done");
    endtask

    task automatic t_done();
        int c;
        // the targets raise completion once their length counts are reached
        wait_sig(3, 1'b1, c);
        repeat (8) @(negedge ref_clk_i);
        `CHK(oe_a, 1'b0, "data pin not released")
        `CHK(sel_a, 2'b11, "memory not released")
        `CHK(oe_b, 1'b0, "data pin not released")
        `CHK(sel_b, 1'b1, "memory not released")
        $display("test done done");
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        t_start();
        t_abort();
        t_done();
        close_out();
    end
endmodule

`default_nettype wire
